/* rtl/bcvd_pkg.sv */
// constants and carrier types for the bunch check, veto delay and clock block
// assumes one 20 MHz clock and a classic wishbone register bus
package bcvd_pkg;
    // ==========================================================
    // sizes
    localparam int NCLU     = 6;
    localparam int NCMP     = 5;
    localparam int NROAD    = 6;
    localparam int NTAP     = 8;
    localparam int NDAC     = 12;
    localparam int VF_DEPTH = 512;
    localparam int VF_AW    = 9;
    // ==========================================================
    // timing
    localparam int MCLK_HZ   = 20_000_000;
    localparam int MCLK_NS   = 50;
    localparam int OSC_HZ    = 20_000_000;
    localparam int OSC_DIV   = MCLK_HZ / OSC_HZ;
    localparam int CLIP_NS   = 10;
    localparam int CLIP_CYC  = (CLIP_NS / MCLK_NS) < 1 ? 1 : CLIP_NS / MCLK_NS;
    localparam int WDOG_NS   = 2000;
    localparam int WDOG_CYC  = WDOG_NS / MCLK_NS;
    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [9:0] REG_STAT  = 10'h000;
    localparam logic [9:0] REG_CMD   = 10'h004;
    localparam logic [9:0] REG_MUX   = 10'h070;
    localparam logic [9:0] REG_EMASK = 10'h072;
    localparam logic [9:0] REG_DELAY = 10'h076;
    localparam logic [9:0] REG_BTEST = 10'h078;
    localparam logic [9:0] REG_CMASK = 10'h07a;
    localparam logic [9:0] REG_DAC   = 10'h07c;
    localparam logic [5:0] AM_SUPER  = 6'h2d;
    localparam logic [5:0] AM_USER   = 6'h29;
    // ==========================================================
    // field positions and reset values
    localparam int CMD_TEST_BIT  = 0;
    localparam int CMD_VETO_BIT  = 2;
    localparam int STAT_ERR_LSB  = 1;
    localparam int STAT_WDOG_BIT = 6;
    localparam int STAT_VFNE_BIT = 8;
    localparam int DAC_NUM_LSB   = 8;
    localparam logic [15:0] CMD_RST = 16'h0000;
    localparam logic [7:0]  REG_RST = 8'h00;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic       full1;
        logic       cyc1;
        logic       bit1;
        logic       full2;
        logic       cyc2;
        logic [7:0] bunch2;
    } bcvd_link_t;
    typedef struct packed {
        logic       cyc1;
        logic       bit1;
        logic       cyc2;
        logic [7:0] bunch2;
    } bcvd_cap_t;
    typedef struct packed {
        logic       flag;
        logic [4:0] bunch;
    } bcvd_veto_t;
    typedef struct packed {
        logic valid;
        logic drop;
        logic veto_n;
    } bcvd_verdict_t;
endpackage : bcvd_pkg

/* rtl/bcvd_top.sv */
// bunch number check, event bunch select, veto delay pipe and fifo,
// board clock tick generation with watchdog, offset converters, bus slave
// assumes link pins are asynchronous to mclk; sequencer and road flags
// run on mclk; the board clock is a one-cycle enable on mclk
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module bcvd_top
    import bcvd_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    input  wire logic                     wb_cyc,
    input  wire logic                     wb_stb,
    input  wire logic                     wb_we,
    input  wire logic [17:0]              wb_adr,
    input  wire logic [31:0]              wb_dat_w,
    input  wire logic [3:0]               wb_sel,
    output logic      [31:0]              wb_dat_r,
    output logic                          wb_ack,
    input  wire logic [5:0]               vme_am,
    input  wire logic [5:0]               board_addr,
    input  wire bcvd_link_t [NCLU-1:0]    link,
    input  wire logic [NROAD-1:0]         road_flags,
    input  wire bcvd_veto_t               veto_in,
    input  wire logic                     seq_rd,
    input  wire logic [4:0]               seq_bunch,
    output logic                          event_wr,
    output logic      [7:0]               event_bunch,
    output logic                          veto_fifo_ne,
    output bcvd_verdict_t                 verdict,
    output logic                          watchdog_led,
    output logic      [NDAC-1:0][7:0]     dac_value
);
    // ==========================================================
    // pin synchronisers
    bcvd_link_t [NCLU-1:0] ls1_q, ls2_q, ls3_q;
    bcvd_veto_t            vs1_q, vs2_q;
    logic [5:0]            bs1_q, bs2_q;

    // two flops before any reader, third copy for edge finding
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ls1_q <= '0;
            ls2_q <= '0;
            ls3_q <= '0;
            vs1_q <= '0;
            vs2_q <= '0;
            bs1_q <= '0;
            bs2_q <= '0;
        end else begin
            ls1_q <= link;
            ls2_q <= ls1_q;
            ls3_q <= ls2_q;
            vs1_q <= veto_in;
            vs2_q <= vs1_q;
            bs1_q <= board_addr;
            bs2_q <= bs1_q;
        end
    end

    // ==========================================================
    // input registers
    bcvd_cap_t [NCLU-1:0] cap_d, cap_q;

    // load on the rise of the inverted full flag
    always_comb begin
        cap_d = cap_q;
        for (int c = 0; c < NCLU; c++) begin
            if (ls3_q[c].full1 && !ls2_q[c].full1) begin
                cap_d[c].cyc1 = ls2_q[c].cyc1;
                cap_d[c].bit1 = ls2_q[c].bit1;
            end
            if (ls3_q[c].full2 && !ls2_q[c].full2) begin
                cap_d[c].cyc2   = ls2_q[c].cyc2;
                cap_d[c].bunch2 = ls2_q[c].bunch2;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) cap_q <= '0;
        else       cap_q <= cap_d;
    end

    // ==========================================================
    // registers written by software
    logic [15:0]          cmd_q, cmd_d;
    logic [2:0]           mux_q, mux_d;
    logic [4:0]           emask_q, emask_d;
    logic [2:0]           delay_q, delay_d;
    logic [7:0]           btest_q, btest_d;
    logic [5:0]           cmask_q, cmask_d;
    logic [11:0]          dacw_q, dacw_d;
    logic [NDAC-1:0][7:0] dac_q, dac_d;
    logic                 test_select, veto_enable_bit;

    assign test_select     = cmd_q[CMD_TEST_BIT];
    assign veto_enable_bit = cmd_q[CMD_VETO_BIT];

    // ==========================================================
    // board clock generation
    logic first_half_pulse, second_half_pulse;
    logic fh_q, sh_q, link_tick, osc_tick, board_tick;
    logic [3:0] osc_cnt_q, osc_cnt_d;

    // masked clusters count as agreeing in both halves
    always_comb begin
        first_half_pulse  = 1'b1;
        second_half_pulse = 1'b1;
        for (int c = 0; c < NCLU; c++) begin
            first_half_pulse  &= cmask_q[c] | (cap_q[c].cyc1 & cap_q[c].cyc2);
            second_half_pulse &= cmask_q[c] | ~(cap_q[c].cyc1 | cap_q[c].cyc2);
        end
    end

    // oscillator divider, one tick per oscillator period
    always_comb begin
        if (osc_cnt_q == 4'(OSC_DIV - 1)) osc_cnt_d = 4'h0;
        else                              osc_cnt_d = osc_cnt_q + 4'h1;
    end
    assign osc_tick = (osc_cnt_q == 4'h0);

    // clipped rising edges of the two halves, ored
    assign link_tick  = (first_half_pulse & ~fh_q) | (second_half_pulse & ~sh_q);
    assign board_tick = test_select ? osc_tick : link_tick;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            fh_q      <= 1'b1;
            sh_q      <= 1'b1;
            osc_cnt_q <= 4'h0;
        end else begin
            fh_q      <= first_half_pulse;
            sh_q      <= second_half_pulse;
            osc_cnt_q <= osc_cnt_d;
        end
    end

    // ==========================================================
    // watchdog on the board clock
    logic [7:0] wd_cnt_q, wd_cnt_d;
    logic       wd_fail_q, wd_fail_d;
    logic       fh_rise, sh_rise, wd_tick, last_first_q, last_first_d;

    // a lost cycle bit leaves one half ticking, so outside test mode only alternating ticks count
    assign fh_rise = first_half_pulse & ~fh_q;
    assign sh_rise = second_half_pulse & ~sh_q;
    assign wd_tick = test_select ? osc_tick
                   : ((fh_rise & ~last_first_q) | (sh_rise & last_first_q));

    always_comb begin
        wd_cnt_d     = wd_cnt_q;
        wd_fail_d    = wd_fail_q;
        last_first_d = last_first_q;
        if (fh_rise) last_first_d = 1'b1;
        else if (sh_rise) last_first_d = 1'b0;
        if (wd_tick) begin
            wd_cnt_d  = 8'h00;
            wd_fail_d = 1'b0;
        end else if (wd_cnt_q == 8'(WDOG_CYC - 1)) begin
            wd_fail_d = 1'b1;
        end else begin
            wd_cnt_d = wd_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wd_cnt_q     <= 8'h00;
            wd_fail_q    <= 1'b0;
            last_first_q <= 1'b0;
        end else begin
            wd_cnt_q     <= wd_cnt_d;
            wd_fail_q    <= wd_fail_d;
            last_first_q <= last_first_d;
        end
    end
    assign watchdog_led = wd_fail_q;

    // ==========================================================
    // bunch comparison
    localparam int CMP_A [NCMP] = '{2, 1, 0, 3, 4};
    localparam int CMP_B [NCMP] = '{1, 0, 3, 4, 5};
    logic [NCMP-1:0] err_raw, err_q, err_d;
    logic            bunch_mismatch_flag;

    function automatic logic [3:0] cmp_bits(input bcvd_cap_t c);
        cmp_bits = {c.bit1, c.bunch2[2:0]};
    endfunction : cmp_bits

    genvar g;
    generate
        for (g = 0; g < NCMP; g++) begin : g_cmp
            assign err_raw[g] = |(cmp_bits(cap_q[CMP_A[g]]) ^ cmp_bits(cap_q[CMP_B[g]]));
        end
    endgenerate

    // masked flags sampled on the board clock
    always_comb begin
        err_d = err_q;
        if (board_tick) err_d = err_raw & emask_q;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) err_q <= '0;
        else       err_q <= err_d;
    end
    assign bunch_mismatch_flag = |err_q;

    // ==========================================================
    // event bunch select, road flag and veto delay pipe
    logic            road_hit_flag, delayed_road_hit_flag;
    logic [7:0]      sel_bunch, ebunch_q, ebunch_d;
    logic [NTAP-1:0] pipe_q, pipe_d;

    always_comb begin
        sel_bunch = 8'h00;
        if (test_select)        sel_bunch = btest_q;
        else if (mux_q < NCLU)  sel_bunch = cap_q[mux_q].bunch2;
    end

    assign road_hit_flag = |road_flags & ~bunch_mismatch_flag;
    assign event_wr      = board_tick & road_hit_flag;
    assign delayed_road_hit_flag = board_tick & pipe_q[delay_q];

    always_comb begin
        ebunch_d = ebunch_q;
        pipe_d   = pipe_q;
        if (event_wr)   ebunch_d = sel_bunch;
        if (board_tick) pipe_d   = {pipe_q[NTAP-2:0], road_hit_flag};
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ebunch_q <= 8'h00;
            pipe_q   <= '0;
        end else begin
            ebunch_q <= ebunch_d;
            pipe_q   <= pipe_d;
        end
    end
    assign event_bunch = ebunch_q;

    // ==========================================================
    // veto fifo and drop decision
    bcvd_veto_t      vmem [VF_DEPTH];
    logic [VF_AW:0]  wp_q, wp_d, rp_q, rp_d;
    logic            vf_empty, vf_full, vf_pop, vmatch;
    bcvd_verdict_t   vd_q, vd_d;

    assign vf_empty     = (wp_q == rp_q);
    assign vf_full      = (wp_q[VF_AW] != rp_q[VF_AW]) && (wp_q[VF_AW-1:0] == rp_q[VF_AW-1:0]);
    assign veto_fifo_ne = ~vf_empty;
    assign vf_pop       = seq_rd & ~vf_empty;
    assign vmatch       = (seq_bunch == vmem[rp_q[VF_AW-1:0]].bunch);

    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        vd_d = '0;
        if (delayed_road_hit_flag && !vf_full) wp_d = wp_q + 1'b1;
        if (vf_pop) begin
            rp_d      = rp_q + 1'b1;
            vd_d.valid  = 1'b1;
            vd_d.veto_n = ~(vmatch & vmem[rp_q[VF_AW-1:0]].flag);
            vd_d.drop   = veto_enable_bit & vmatch & vmem[rp_q[VF_AW-1:0]].flag;
        end
    end

    // memory array written by the delayed road flag
    always_ff @(posedge mclk) begin
        if (delayed_road_hit_flag && !vf_full) vmem[wp_q[VF_AW-1:0]] <= vs2_q;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wp_q <= '0;
            rp_q <= '0;
            vd_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            vd_q <= vd_d;
        end
    end
    assign verdict = vd_q;

    // ==========================================================
    // wishbone slave
    logic        am_ok, hit, access, wr_en, ack_q, ack_d;
    logic [9:0]  idx;
    logic [31:0] rd_q, rd_d, rd_mux;

    assign am_ok  = (vme_am == AM_SUPER) || (vme_am == AM_USER);
    assign idx    = wb_adr[11:2];
    assign hit    = am_ok && (wb_adr[17:12] == bs2_q) && (wb_adr[1:0] == 2'b00);
    assign access = wb_cyc & wb_stb & ~ack_q;
    assign wr_en  = access & wb_we & hit & (wb_sel[1:0] == 2'b11);

    // read data, zero for anything unmapped
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            REG_STAT: begin
                rd_mux[STAT_ERR_LSB +: NCMP] = {err_q[2], err_q[4], err_q[3], err_q[0], err_q[1]};
                rd_mux[STAT_WDOG_BIT]        = wd_fail_q;
                rd_mux[STAT_VFNE_BIT]        = ~vf_empty;
            end
            REG_CMD:   rd_mux[15:0] = cmd_q;
            REG_MUX:   rd_mux[2:0]  = mux_q;
            REG_EMASK: rd_mux[4:0]  = emask_q;
            REG_DELAY: rd_mux[2:0]  = delay_q;
            REG_BTEST: rd_mux[7:0]  = btest_q;
            REG_CMASK: rd_mux[5:0]  = cmask_q;
            REG_DAC:   rd_mux[11:0] = dacw_q;
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    // register writes; a write to index zero clears mux, emask, delay, btest and cmask, but not cmd or the dac registers
    always_comb begin
        cmd_d   = cmd_q;
        mux_d   = mux_q;
        emask_d = emask_q;
        delay_d = delay_q;
        btest_d = btest_q;
        cmask_d = cmask_q;
        dacw_d  = dacw_q;
        dac_d   = dac_q;
        ack_d   = access;
        rd_d    = 32'h0000_0000;
        if (access && !wb_we && hit) rd_d = rd_mux;
        if (wr_en) begin
            case (idx)
                REG_STAT: begin
                    mux_d   = REG_RST[2:0];
                    emask_d = REG_RST[4:0];
                    delay_d = REG_RST[2:0];
                    btest_d = REG_RST;
                    cmask_d = REG_RST[5:0];
                end
                REG_CMD:   cmd_d   = wb_dat_w[15:0];
                REG_MUX:   mux_d   = wb_dat_w[2:0];
                REG_EMASK: emask_d = wb_dat_w[4:0];
                REG_DELAY: delay_d = wb_dat_w[2:0];
                REG_BTEST: btest_d = wb_dat_w[7:0];
                REG_CMASK: cmask_d = wb_dat_w[5:0];
                REG_DAC: begin
                    dacw_d = wb_dat_w[11:0];
                    if (wb_dat_w[DAC_NUM_LSB +: 4] < NDAC)
                        dac_d[wb_dat_w[DAC_NUM_LSB +: 4]] = wb_dat_w[7:0];
                end
                default: cmd_d = cmd_q;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cmd_q   <= CMD_RST;
            mux_q   <= REG_RST[2:0];
            emask_q <= REG_RST[4:0];
            delay_q <= REG_RST[2:0];
            btest_q <= REG_RST;
            cmask_q <= REG_RST[5:0];
            dacw_q  <= 12'h000;
            dac_q   <= '0;
            ack_q   <= 1'b0;
            rd_q    <= 32'h0000_0000;
        end else begin
            cmd_q   <= cmd_d;
            mux_q   <= mux_d;
            emask_q <= emask_d;
            delay_q <= delay_d;
            btest_q <= btest_d;
            cmask_q <= cmask_d;
            dacw_q  <= dacw_d;
            dac_q   <= dac_d;
            ack_q   <= ack_d;
            rd_q    <= rd_d;
        end
    end
    assign wb_ack    = ack_q;
    assign wb_dat_r  = rd_q;
    assign dac_value = dac_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_request;
        wb_cyc && wb_stb && !wb_ack;
    endsequence
    sequence s_answer;
        wb_ack ##1 !wb_ack;
    endsequence
    sequence s_tick_gap;
        (!board_tick)[*7] ##1 board_tick;
    endsequence

    a_bus_ack_timing: assert property (s_request |=> s_answer)
        else $error("ack not one cycle after request");
    a_bad_am_read: assert property (s_request ##0 (!am_ok && !wb_we) |=> wb_dat_r == 32'h0)
        else $error("read answered with bad modifier");
    a_foreign_board: assert property (s_request ##0 (wb_adr[17:12] != bs2_q && wb_we)
            |=> $stable(cmd_q) && $stable(delay_q))
        else $error("write taken for another board");
    a_event_gated: assert property (event_wr |-> !bunch_mismatch_flag && board_tick)
        else $error("event written during mismatch");
    a_masked_quiet: assert property ($rose(err_q[0]) |-> $past(emask_q[0]))
        else $error("masked comparison raised flag");
    a_veto_tap_zero: assert property (delay_q == 3'h0 && event_wr ##1 s_tick_gap
            ##0 delay_q == 3'h0 |-> delayed_road_hit_flag)
        else $error("veto strobe missed after zero delay");
    a_no_pop_empty: assert property (seq_rd && vf_empty |=> !verdict.valid)
        else $error("verdict from empty veto fifo");
    a_drop_enable: assert property (verdict.drop |-> verdict.valid && !verdict.veto_n
            && $past(veto_enable_bit))
        else $error("drop without enable or flag");
    a_wdog_timeout: assert property (!wd_tick [*8] ##0 wd_cnt_q == 8'(WDOG_CYC - 1)
            |=> watchdog_led)
        else $error("watchdog did not fire");
    a_test_bunch: assert property (test_select && event_wr |=> event_bunch == $past(btest_q))
        else $error("test bunch not used");
    a_clip_width: assert property (link_tick |=> !link_tick)
        else $error("clock pulse longer than clip");
endmodule : bcvd_top

/* tb/bcvd_link_model.sv */
// link deserializer and veto source model
// assumes lclk runs free from the bench, unrelated to mclk
`timescale 1ns/10ps
module bcvd_link_model
    import bcvd_pkg::*;
(
    input  wire logic             lclk,
    input  wire logic [NCLU-1:0]  kill,
    input  wire logic [NCLU-1:0]  bad,
    input  wire bcvd_veto_t       vset,
    output bcvd_link_t [NCLU-1:0] link,
    output bcvd_veto_t            veto
);
    logic       cyc = 1'b0;
    logic [7:0] bun = 8'h00;
    // =====================================
    // new frame on rise, bad flips the first-link bunch bit;
    // full flags fall mid frame unless the link is dead
    always @(lclk) begin
        if (lclk) begin
            cyc = ~cyc;
            bun = bun + {7'h00, cyc};
            veto <= vset;
            for (int i = 0; i < NCLU; i++) begin
                link[i] <= '{1'b1, cyc, bun[0] ^ bad[i], 1'b1, cyc, bun};
            end
        end else begin
            for (int i = 0; i < NCLU; i++) begin
                link[i].full1 <= kill[i];
                link[i].full2 <= kill[i];
            end
        end
    end
endmodule : bcvd_link_model

/* tb/bcvd_top_bench.sv */
// register, bunch check, veto and board clock tests
// assumes the link model stands in for deserializers and veto source
`timescale 1ns/10ps
module bcvd_top_bench
    import bcvd_pkg::*;
;
    logic mclk = 0, nrst = 0, lclk = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0;
    logic [17:0] wb_adr = '0;
    logic [31:0] wb_dat_w = '0, wb_dat_r, r;
    logic [3:0] wb_sel = 4'hf;
    logic [5:0] vme_am = AM_USER, bsel = 6'h15, road_flags = '0, kill = '0, bad = '0;
    logic wb_ack, seq_rd = 0, event_wr, veto_fifo_ne, watchdog_led;
    logic [4:0] seq_bunch = '0;
    logic [7:0] event_bunch;
    logic [NDAC-1:0][7:0] dac_value;
    bcvd_link_t [NCLU-1:0] link;
    bcvd_veto_t veto_in, vset = '0;
    bcvd_verdict_t verdict;
    int fail_count = 0, compares = 0, ev_n = 0, n;
    // =====================================
    // clocks, event counter, parts
    initial forever #25 mclk = ~mclk;
    initial begin
        #37;
        forever #200 lclk = ~lclk;
    end
    always @(negedge mclk) ev_n += (event_wr === 1'b1);
    bcvd_link_model lm (.lclk(lclk), .kill(kill), .bad(bad), .vset(vset), .link(link),
        .veto(veto_in));
    bcvd_top dut (.mclk(mclk), .nrst(nrst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_dat_w(wb_dat_w), .wb_sel(wb_sel), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .vme_am(vme_am), .board_addr(6'h15), .link(link),
        .road_flags(road_flags), .veto_in(veto_in), .seq_rd(seq_rd), .seq_bunch(seq_bunch),
        .event_wr(event_wr), .event_bunch(event_bunch), .veto_fifo_ne(veto_fifo_ne),
        .verdict(verdict), .watchdog_led(watchdog_led), .dac_value(dac_value));
    // =====================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {bsel, idx, 2'b00};
        wb_dat_w <= d;
        do @(posedge mclk); while (wb_ack !== 1'b1);
        r = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge mclk);
    endtask : wb
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask : cyc
    task automatic one_event;
        road_flags <= 6'h04;
        do @(negedge mclk); while (event_wr !== 1'b1);
        @(posedge mclk);
        road_flags <= '0;
    endtask : one_event
    task end_sim;
        $display("mismatches %0d, compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // =====================================
    // watchdog on the whole run
    initial begin
        #2_000_000;
        fail_count++;
        end_sim();
    end
    // main sequence
    logic [9:0] ri [5] = '{REG_MUX, REG_EMASK, REG_DELAY, REG_BTEST, REG_CMASK};
    logic [2:0] dl [4] = '{3'h0, 3'h7, 3'h3, 3'h1};
    logic [3:0] vx [4] = '{4'hf, 4'h7, 4'hc, 4'ha}; // en, flag, match, match and flag
    initial begin
        cyc(16);
        nrst <= 1'b1;
        cyc(60);
        for (int i = 0; i < 5; i++) begin
            wb(0, ri[i], 0); chk(r, 0);
            wb(1, ri[i], 5); wb(0, ri[i], 0); chk(r, 5);
        end
        wb(0, 10'h3ff, 0); chk(r, 0);
        bsel = 6'h16; wb(1, REG_DELAY, 2); wb(0, REG_MUX, 0); chk(r, 0);
        bsel = 6'h15; wb(0, REG_DELAY, 0); chk(r, 5);
        vme_am <= AM_SUPER; wb(0, REG_MUX, 0); chk(r, 5);
        vme_am <= 6'h39; wb(0, REG_MUX, 0); chk(r, 0);
        vme_am <= AM_USER; wb(1, REG_STAT, 0); wb(0, REG_MUX, 0); chk(r, 0);
        wb(1, REG_DAC, 32'h3a5); chk(dac_value[3], 8'ha5);
        wb(1, REG_DAC, 32'hc33); chk(dac_value[3], 8'ha5);
        // veto alignment, match and enable cases
        for (int i = 0; i < 4; i++) begin
            vset <= '{vx[i][2], 5'h0a};
            wb(1, REG_CMD, {vx[i][3], 2'b00});
            wb(1, REG_DELAY, dl[i]);
            cyc(20);
            one_event();
            n = 0;
            while (veto_fifo_ne !== 1'b1 && n < 200) begin @(negedge mclk); n++; end
            chk(n >= dl[i] * 8 + 6 && n <= dl[i] * 8 + 12, 1);
            @(posedge mclk);
            seq_bunch <= vx[i][1] ? 5'h0a : 5'h0b;
            seq_rd <= 1'b1;
            @(posedge mclk);
            seq_rd <= 1'b0;
            @(negedge mclk);
            chk(verdict, {1'b1, vx[i][0] & vx[i][3], ~vx[i][0]});
            // let the event leave the pipe before the delay changes
            cyc(70);
        end
        seq_rd <= 1'b1;
        @(posedge mclk);
        seq_rd <= 1'b0;
        @(negedge mclk);
        chk(verdict.valid, 0);
        cyc(1);
        // bunch compare with a bad layer3 left link
        wb(1, REG_EMASK, 32'h1f);
        bad <= 6'h04;
        cyc(40);
        wb(0, REG_STAT, 0); chk(r & 32'h3e, 32'h04);
        n = ev_n; road_flags <= 6'h01; cyc(40);
        chk(ev_n - n, 0);
        wb(1, REG_EMASK, 32'h1e); cyc(40);
        wb(0, REG_STAT, 0); chk(r & 32'h3e, 0);
        n = ev_n; cyc(40); road_flags <= 0;
        chk(ev_n - n > 3, 1);
        // dead link, watchdog, clock mask
        kill <= 6'h08; cyc(80);
        chk(watchdog_led, 1); wb(0, REG_STAT, 0); chk(r[STAT_WDOG_BIT], 1);
        wb(1, REG_CMASK, 32'h08); cyc(80);
        chk(watchdog_led, 0);
        kill <= '0; bad <= '0; cyc(40);
        // test mode: local clock and bunch test register
        wb(1, REG_BTEST, 32'h5a); wb(1, REG_CMD, 32'h1);
        road_flags <= 6'h20; cyc(4); @(negedge mclk);
        chk(event_wr, 1); chk(event_bunch, 8'h5a);
        @(negedge mclk); chk(event_wr, 1);
        @(posedge mclk); road_flags <= 0;
        wb(1, REG_CMD, 0); wb(1, REG_MUX, 6); one_event(); @(negedge mclk);
        chk(event_bunch, 0);
        end_sim();
    end
endmodule : bcvd_top_bench
